// ==== mpoc_ms_tick.sv ====
// Purpose: Shared constants and types for the power on/off sequencer, plus its millisecond time base
// Assumes: ref_clk at 25 MHz, synchronous active-high rst
// Notes:   The tick divider is the only long cycle count, so its length is a parameter

`timescale 1ns/10ps
`default_nettype none

package mpoc_pkg;
    // Time base
    localparam int CLK_HZ        = 25_000_000;
    localparam int MS_PER_S      = 1000;
    localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
    localparam int TICK_W        = 16;

    // Counter widths in milliseconds
    localparam int KEY_W = 11;
    localparam int RST_W = 10;
    localparam int SEQ_W = 8;

    // Pulse thresholds and sequencer hold times, in milliseconds unless the unit says otherwise
    localparam logic [KEY_W-1:0] KEY_ON_MS          = 11'h064;
    localparam logic [KEY_W-1:0] KEY_ON_ADVISED_MS  = 11'h0c8;
    localparam int               KEY_OFF_S          = 2;
    localparam logic [KEY_W-1:0] KEY_OFF_MS         = KEY_W'(KEY_OFF_S * MS_PER_S);
    localparam logic [RST_W-1:0] RST_OFF_MS         = 10'h384;
    localparam int               RST_OFF_ADVISED_S  = 1;
    localparam logic [RST_W-1:0] RST_OFF_ADVISED_MS = RST_W'(RST_OFF_ADVISED_S * MS_PER_S);
    localparam logic [SEQ_W-1:0] BOOT_MS            = 8'h32;
    localparam logic [SEQ_W-1:0] RST_HOLD_MS        = 8'h0a;

    typedef enum logic [3:0] {
        ST_OFF   = 4'h1,
        ST_BOOT  = 4'h2,
        ST_ON    = 4'h4,
        ST_RESET = 4'h8
    } mpoc_state_type;

    // Pins from the host side, all sampled as synchronous levels
    typedef struct packed {
        logic supplyOk;
        logic powerKeyInput;
        logic resetInput;
        logic powerOnTriggerInput;
    } mpoc_pins_type;

    // Power controls toward the rest of the module
    typedef struct packed {
        logic moduleOn;
        logic moduleReset;
        logic pinsValid;
    } mpoc_status_type;

    typedef struct packed {
        mpoc_state_type    st;
        logic [KEY_W-1:0]  keyMs;
        logic [RST_W-1:0]  rstMs;
        logic [SEQ_W-1:0]  seqMs;
        logic              keyArmed;
        logic              rstArmed;
        logic              trgArmed;
        logic              rstWasLow;
        mpoc_status_type   out;
    } mpoc_main_type;

    typedef struct packed {
        logic [TICK_W-1:0] cnt;
        logic              tick;
    } mpoc_tick_type;
endpackage

module mpoc_ms_tick #(
    parameter int CYCLES = mpoc_pkg::CYCLES_PER_MS
) (
    input  wire logic ref_clk,  // System clock
    input  wire logic rst,      // Synchronous reset
    output logic      msTick    // One-cycle pulse per millisecond
);
    import mpoc_pkg::*;

    localparam logic [TICK_W-1:0] LAST = TICK_W'(CYCLES - 1);

    mpoc_tick_type r;
    mpoc_tick_type next_r;

    // Free-running divider; CYCLES must not exceed the counter range
    always_comb begin
        next_r      = r;
        next_r.tick = (r.cnt == LAST);
        next_r.cnt  = (r.cnt == LAST) ? '0 : r.cnt + 16'h0001;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign msTick = r.tick;
endmodule

`default_nettype wire

// ==== mpoc_power_ctrl.sv ====
// Purpose: Pulse-width decoder that turns the module on, resets it or turns it off
// Assumes: Inputs already synchronous to ref_clk; supplyOk marks main supply present
// Notes:   Widths are measured in whole milliseconds, so each threshold has a 1 ms jitter
//
// Operation
// - With supply present, a power key low for at least 100 ms powers on (200 ms advised).
// - While running, a power key low for 2 seconds powers off.
// - While working, a low pulse on the reset input shorter than 900 ms resets the module.
// - While working, a reset low pulse longer than 900 ms powers off.
// - A high level on the power-on trigger input powers the module on.
// - A power key held low permanently starts the module once supply has been present for 100 ms.
// - Pin states are not valid until the power-on sequence has finished.

`timescale 1ns/10ps
`default_nettype none

module mpoc_power_ctrl #(
    parameter int CYCLES_PER_MS = mpoc_pkg::CYCLES_PER_MS
) (
    input  wire logic                      ref_clk,  // 25 MHz clock
    input  wire logic                      rst,      // Synchronous reset, active high
    input  wire mpoc_pkg::mpoc_pins_type   pins,     // Supply flag and the three control pins
    output var mpoc_pkg::mpoc_status_type  status    // Registered power controls
);
    import mpoc_pkg::*;

    logic          msTick;
    mpoc_main_type r;
    mpoc_main_type next_r;
    logic          keyLow;
    logic          rstLow;
    logic          rstRise;

    mpoc_ms_tick #(
        .CYCLES (CYCLES_PER_MS)
    ) u_tick (
        .ref_clk (ref_clk),
        .rst     (rst),
        .msTick  (msTick)
    );

    // Pin decode; reset release is the moment a short pulse is judged
    assign keyLow  = !pins.powerKeyInput;
    assign rstLow  = !pins.resetInput;
    assign rstRise = r.rstWasLow && !rstLow;

    // Next state: arming, pulse timers, then the sequencer, which has the last word
    always_comb begin
        next_r           = r;
        next_r.rstWasLow = rstLow;

        // A pin must return to its idle level (key and reset high, trigger low), or supply must drop, before it may act again, so a held level cannot retrigger
        if (!keyLow) begin
            next_r.keyArmed = 1'b1;
        end
        if (!rstLow) begin
            next_r.rstArmed = 1'b1;
        end
        if (!pins.powerOnTriggerInput) begin
            next_r.trgArmed = 1'b1;
        end
        if (!pins.supplyOk) begin
            next_r.keyArmed = 1'b1;
            next_r.rstArmed = 1'b1;
            next_r.trgArmed = 1'b1;
        end

        // Saturating millisecond timers of the current low pulse
        // Timing starts only with supply present, so a key held through a supply gap
        // still needs a full press after the supply returns
        if (!keyLow || !r.keyArmed || !pins.supplyOk) begin
            next_r.keyMs = '0;
        end else if (msTick && r.keyMs != KEY_OFF_MS) begin
            next_r.keyMs = r.keyMs + 11'h001;
        end
        if (!rstLow || !r.rstArmed || !pins.supplyOk) begin
            next_r.rstMs = '0;
        end else if (msTick && r.rstMs != RST_OFF_MS) begin
            next_r.rstMs = r.rstMs + 10'h001;
        end

        // Power sequencer
        if (!pins.supplyOk) begin
            next_r.st    = ST_OFF;
            next_r.seqMs = '0;
        end else begin
            case (r.st)
                ST_OFF: begin
                    if ((r.keyArmed && r.keyMs >= KEY_ON_MS) ||
                        (r.trgArmed && pins.powerOnTriggerInput)) begin
                        next_r.st       = ST_BOOT;
                        next_r.seqMs    = '0;
                        next_r.keyArmed = 1'b0;
                        next_r.trgArmed = 1'b0;
                    end
                end
                ST_BOOT: begin
                    if (r.seqMs >= BOOT_MS) begin
                        next_r.st = ST_ON;
                    end else if (msTick) begin
                        next_r.seqMs = r.seqMs + 8'h01;
                    end
                end
                ST_ON: begin
                    if (r.keyArmed && r.keyMs >= KEY_OFF_MS) begin
                        next_r.st       = ST_OFF;
                        next_r.keyArmed = 1'b0;
                    end else if (r.rstArmed && r.rstMs >= RST_OFF_MS) begin
                        next_r.st       = ST_OFF;
                        next_r.rstArmed = 1'b0;
                    end else if (rstRise && r.rstArmed) begin
                        next_r.st    = ST_RESET;
                        next_r.seqMs = '0;
                    end
                end
                ST_RESET: begin
                    // Reset is held a fixed time, then the module boots again
                    if (r.seqMs >= RST_HOLD_MS) begin
                        next_r.st    = ST_BOOT;
                        next_r.seqMs = '0;
                    end else if (msTick) begin
                        next_r.seqMs = r.seqMs + 8'h01;
                    end
                end
                default: begin
                    next_r.st = ST_OFF;
                end
            endcase
        end

        // Outputs follow the state being entered, so they change with it
        next_r.out.moduleOn    = (next_r.st != ST_OFF);
        next_r.out.moduleReset = (next_r.st == ST_RESET);
        next_r.out.pinsValid   = (next_r.st == ST_ON);
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r          <= '0;
            r.st       <= ST_OFF;
            r.keyArmed <= 1'b1;
            r.rstArmed <= 1'b1;
            r.trgArmed <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign status = r.out;

    // Checks on the sequencer
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_key_on;
        r.st == ST_OFF && pins.supplyOk && r.keyArmed && r.keyMs >= KEY_ON_MS
            |=> r.st == ST_BOOT && status.moduleOn;
    endproperty
    a_key_on: assert property (p_key_on) else $error("key pulse did not power on");

    property p_key_off;
        r.st == ST_ON && pins.supplyOk && r.keyArmed && r.keyMs >= KEY_OFF_MS
            |=> r.st == ST_OFF && !status.moduleOn;
    endproperty
    a_key_off: assert property (p_key_off) else $error("long key pulse did not power off");

    property p_rst_short;
        r.st == ST_ON && pins.supplyOk && rstRise && r.rstArmed && r.rstMs < RST_OFF_MS &&
            !(r.keyArmed && r.keyMs >= KEY_OFF_MS)
            |=> status.moduleReset && status.moduleOn;
    endproperty
    a_rst_short: assert property (p_rst_short) else $error("short reset pulse ignored");

    property p_rst_long;
        r.st == ST_ON && pins.supplyOk && r.rstArmed && r.rstMs >= RST_OFF_MS
            |=> r.st == ST_OFF;
    endproperty
    a_rst_long: assert property (p_rst_long) else $error("long reset pulse did not power off");

    property p_trig_on;
        r.st == ST_OFF && pins.supplyOk && r.trgArmed && pins.powerOnTriggerInput
            |=> r.st == ST_BOOT;
    endproperty
    a_trig_on: assert property (p_trig_on) else $error("trigger did not power on");

    property p_supply_arms;
        !pins.supplyOk |=> r.keyArmed && r.st == ST_OFF && !status.moduleOn;
    endproperty
    a_supply_arms: assert property (p_supply_arms) else $error("supply loss left key unarmed");

    property p_boot_blind;
        $rose(r.st == ST_BOOT) |-> !status.pinsValid [*8];
    endproperty
    a_boot_blind: assert property (p_boot_blind) else $error("pins valid during boot");

    property p_valid_on;
        status.pinsValid |-> r.st == ST_ON && status.moduleOn && !status.moduleReset;
    endproperty
    a_valid_on: assert property (p_valid_on) else $error("pins valid outside on state");

    property p_ms_step;
        r.keyMs != $past(r.keyMs) && r.keyMs != '0 |-> $past(msTick) && r.keyMs == $past(r.keyMs) + 11'h001;
    endproperty
    a_ms_step: assert property (p_ms_step) else $error("key timer moved off tick");

    c_key_on: cover property (r.st == ST_OFF ##1 r.st == ST_BOOT);
    c_reset:  cover property (r.st == ST_ON ##1 r.st == ST_RESET);
    c_off:    cover property (r.st == ST_ON ##1 r.st == ST_OFF);
    c_ready:  cover property ($rose(status.pinsValid));
endmodule

`default_nettype wire

// ==== mpoc_host_model.sv ====
// Purpose: Host stand-in that drives the supply flag and the three control pins
// Assumes: Every change lands 1 ns after a rising edge of ref_clk
// Notes:   Pins hold their level until the next call, so none floats
`timescale 1ns/10ps
`default_nettype none

module mpoc_host_model #(
    parameter int CPM = 10
) (
    input  wire logic                   ref_clk, // System clock
    output var mpoc_pkg::mpoc_pins_type pins     // Supply flag and control pins
);
    import mpoc_pkg::*;

    // Idle levels: no supply, key and reset released, trigger low
    initial begin
        pins = 4'h6;
    end

    // Changes land just after the edge so the sequencer never sees a race
    task automatic drive(input int sel, input logic val);
        @(posedge ref_clk);
        #1;
        case (sel)
            0: pins.supplyOk = val;
            1: pins.powerKeyInput = val;
            2: pins.resetInput = val;
            default: pins.powerOnTriggerInput = val;
        endcase
    endtask

    // Waits whole milliseconds, then steps off the edge
    task automatic waitMs(input int ms);
        repeat (ms * CPM) @(posedge ref_clk);
        #1;
    endtask

    // Advised press, twice the minimum for margin
    task automatic keyPulseOn();
        drive(1, 1'b0);
        waitMs(int'(KEY_ON_ADVISED_MS));
        drive(1, 1'b1);
    endtask

    // Off through reset is held well past its threshold
    task automatic rstPulseOff();
        drive(2, 1'b0);
        waitMs(int'(RST_OFF_ADVISED_MS));
        drive(2, 1'b1);
    endtask
endmodule

`default_nettype wire

// ==== tb.sv ====
// Purpose: Self-checking bench for the power on/off sequencer
// Assumes: A 10-cycle millisecond keeps the long presses short
// Notes:   Windows allow for the partial first tick of each count
`timescale 1ns/10ps
`default_nettype none

module tb;
    import mpoc_pkg::*;
    localparam int CPM = 10;
    logic            ref_clk;
    logic            rst;
    mpoc_pins_type   pins;
    mpoc_status_type status;
    int              numErrors;
    int              testsRun;

    mpoc_host_model #(.CPM(CPM)) host (.ref_clk(ref_clk), .pins(pins));
    mpoc_power_ctrl #(.CYCLES_PER_MS(CPM)) dut (
        .ref_clk(ref_clk), .rst(rst), .pins(pins), .status(status));

    // 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic testDone();
        if (numErrors == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic got, input logic exp, input string msg);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    // Bounded wait on one status bit: 2 on, 1 reset, 0 valid
    task automatic waitBit(input int idx, input logic val, input int maxCyc);
        int n;
        n = 0;
        while (status[idx] !== val && n < maxCyc) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(status[idx], val, "status bit late");
        if (status[idx] !== val) begin
            testDone();
        end
    endtask

    // Key press powers on; pins stay invalid through boot
    task automatic keyOn();
        host.drive(0, 1'b1);
        fork
            host.keyPulseOn();
        join_none
        host.waitMs(98);
        check(status.moduleOn, 1'b0, "on too early");
        waitBit(2, 1'b1, 30);
        check(status.pinsValid, 1'b0, "valid during boot");
        host.waitMs(48);
        check(status.pinsValid, 1'b0, "valid too early");
        waitBit(0, 1'b1, 40);
        host.waitMs(60);
    endtask

    task automatic resetShort();
        host.drive(2, 1'b0);
        host.waitMs(100);
        host.drive(2, 1'b1);
        waitBit(1, 1'b1, 3);
        check(status.pinsValid, 1'b0, "valid in reset");
        check(status.moduleOn, 1'b1, "off after short pulse");
        waitBit(1, 1'b0, 120);
        waitBit(0, 1'b1, 520);
    endtask

    // Long pulse is decided at the limit, before release
    task automatic resetLong();
        fork
            host.rstPulseOff();
        join_none
        host.waitMs(895);
        check(status.moduleOn, 1'b1, "off too early");
        waitBit(2, 1'b0, 80);
        check(status.pinsValid, 1'b0, "valid when off");
        host.waitMs(150);
        check(status.moduleOn, 1'b0, "reset acted while off");
    endtask

    task automatic trigOn();
        host.drive(3, 1'b1);
        waitBit(2, 1'b1, 3);
        host.drive(3, 1'b0);
        waitBit(0, 1'b1, 520);
    endtask

    task automatic keyOff();
        host.drive(1, 1'b0);
        host.waitMs(1990);
        check(status.moduleOn, 1'b1, "off too early");
        waitBit(2, 1'b0, 120);
        host.waitMs(150);
        check(status.moduleOn, 1'b0, "held key powered on");
        host.drive(1, 1'b1);
    endtask

    // Key tied low starts the module once supply returns
    task automatic autoStart();
        host.drive(1, 1'b0);
        host.drive(0, 1'b0);
        host.waitMs(2);
        host.drive(0, 1'b1);
        host.waitMs(95);
        check(status.moduleOn, 1'b0, "auto start too early");
        waitBit(2, 1'b1, 1010);
        waitBit(0, 1'b1, 520);
        host.drive(0, 1'b0);
        waitBit(2, 1'b0, 3);
        host.drive(1, 1'b1);
    endtask

    // Main sequence
    initial begin
        numErrors = 0;
        testsRun = 0;
        rst = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        check(status.moduleOn, 1'b0, "on after reset");
        keyOn();
        resetShort();
        resetLong();
        trigOn();
        keyOff();
        autoStart();
        testDone();
    end
endmodule

`default_nettype wire
